// >>> hw/rfmos_regs.vh
// Constants for the option control registers and the status byte of the modulator serial port
`ifndef RFMOS_REGS_VH
`define RFMOS_REGS_VH

// ----------------------------------------------------------------
// Option register layout and reset values
// ----------------------------------------------------------------
`define RFMOS_OPT_ADR_BIT     15
`define RFMOS_OPT1_RESET      16'h8000
`define RFMOS_OPT2_RESET      16'h8005
`define RFMOS_CLIP_HI_BIT     1
`define RFMOS_CLIP_LO_BIT     0

// ----------------------------------------------------------------
// Clip level codes and video modulation depth in tenths of a percent
// ----------------------------------------------------------------
`define RFMOS_CLIP_900        2'b00
`define RFMOS_CLIP_940        2'b01
`define RFMOS_CLIP_910        2'b10
`define RFMOS_CLIP_925        2'b11
`define RFMOS_DEPTH_900       10'h0_384
`define RFMOS_DEPTH_940       10'h0_3AC
`define RFMOS_DEPTH_910       10'h0_38E
`define RFMOS_DEPTH_925       10'h0_39D

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define RFMOS_STAT_OOR_BIT    0
`define RFMOS_STAT_BAND_BIT   1
`define RFMOS_STAT_DIR_BIT    2

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define RFMOS_BITS_PER_BYTE   4'h8
`define RFMOS_READ_BYTES      2'h3
`define RFMOS_IDLE_BYTE       8'hFF
`define RFMOS_BUS_MAX_KHZ     800

`endif

// >>> hw/rfmos_regs.v
// Serial slave holding the two option control registers and the oscillator status byte
`timescale 1ns/1ps
`include "rfmos_regs.vh"

module rfmos_regs #(
  parameter [6:0] DEV_ADDR     = 7'h50, // Arbitrary bus address
  parameter       OSC_OFF_LEVEL = 1'b0  // Level of control bit 6 that turns the oscillator off
) (
  // Clock and reset
  input  wire        clock,
  input  wire        nrst,
  // Serial bus pins
  input  wire        scl,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe_n,
  // Oscillator control and monitor
  input  wire        osc_ctrl_bit,
  input  wire        vco_out_of_range,
  input  wire        vco_too_high,
  input  wire        low_vco_active,
  output reg         osc_disabled,
  // Register contents
  output reg  [15:0] option_control_one,
  output reg  [15:0] option_control_two,
  output reg  [1:0]  clip_level_sel,
  output reg  [9:0]  clip_depth_permille
);

  // ----------------------------------------------------------------
  // States and helpers
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ADDR  = 3'd1;
  localparam [2:0] ST_AACK  = 3'd2;
  localparam [2:0] ST_WRITE = 3'd3;
  localparam [2:0] ST_WACK  = 3'd4;
  localparam [2:0] ST_READ  = 3'd5;
  localparam [2:0] ST_RACK  = 3'd6;

  // Depth of modulation for a clip code
  function [9:0] depth_of;
    input [1:0] code;
    begin
      case (code)
        `RFMOS_CLIP_900: depth_of = `RFMOS_DEPTH_900;
        `RFMOS_CLIP_940: depth_of = `RFMOS_DEPTH_940;
        `RFMOS_CLIP_910: depth_of = `RFMOS_DEPTH_910;
        default:         depth_of = `RFMOS_DEPTH_925;
      endcase
    end
  endfunction

  reg [2:0]  state;
  reg        scl_q;
  reg        sda_q;
  reg [3:0]  bit_cnt;
  reg [7:0]  rx_shift;
  reg [7:0]  tx_shift;
  reg        read_mode;
  reg        drive_low;
  reg        high_phase;
  reg [7:0]  high_byte;
  reg [1:0]  word_idx;
  reg [1:0]  read_idx;
  reg [7:0]  status_q;
  reg [7:0]  next_tx;

  wire scl_rise  = scl & ~scl_q;
  wire scl_fall  = ~scl & scl_q;
  wire start_seen = scl & scl_q & sda_q & ~sda_in;
  wire stop_seen  = scl & scl_q & ~sda_q & sda_in;
  wire byte_full  = (bit_cnt == `RFMOS_BITS_PER_BYTE);
  wire [15:0] rx_word = {high_byte, rx_shift};

  // Open drain: only ever pull low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_low;

  // ----------------------------------------------------------------
  // Oscillator monitor and outputs
  // ----------------------------------------------------------------
  // Status tracks the monitor every cycle, reserved bits zero
  always @(posedge clock) begin
    if (!nrst) begin
      status_q     <= 8'h00;
      osc_disabled <= 1'b0;
    end else begin
      status_q <= 8'h00;
      status_q[`RFMOS_STAT_OOR_BIT]  <= vco_out_of_range;
      status_q[`RFMOS_STAT_BAND_BIT] <= low_vco_active;
      status_q[`RFMOS_STAT_DIR_BIT]  <= vco_too_high & vco_out_of_range;
      osc_disabled <= (osc_ctrl_bit == OSC_OFF_LEVEL);
    end
  end

  // Clip selection decoded from option register two
  always @(posedge clock) begin
    if (!nrst) begin
      clip_level_sel      <= 2'b00;
      clip_depth_permille <= `RFMOS_DEPTH_900;
    end else begin
      clip_level_sel      <= option_control_two[`RFMOS_CLIP_HI_BIT:`RFMOS_CLIP_LO_BIT];
      clip_depth_permille <= depth_of(option_control_two[`RFMOS_CLIP_HI_BIT:`RFMOS_CLIP_LO_BIT]);
    end
  end

  // Byte returned for each read position
  always @* begin
    case (read_idx)
      2'd0:    next_tx = status_q;
      2'd1:    next_tx = option_control_one[7:0];
      2'd2:    next_tx = option_control_two[7:0];
      default: next_tx = `RFMOS_IDLE_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  // Bus sampled on system clock, ample margin over the fastest SCL
  always @(posedge clock) begin
    if (!nrst) begin
      state              <= ST_IDLE;
      scl_q              <= 1'b1;
      sda_q              <= 1'b1;
      bit_cnt            <= 4'h0;
      rx_shift           <= 8'h00;
      tx_shift           <= 8'h00;
      read_mode          <= 1'b0;
      drive_low          <= 1'b0;
      high_phase         <= 1'b1;
      high_byte          <= 8'h00;
      word_idx           <= 2'd0;
      read_idx           <= 2'd0;
      option_control_one <= `RFMOS_OPT1_RESET;
      option_control_two <= `RFMOS_OPT2_RESET;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      if (start_seen) begin
        state      <= ST_ADDR;
        bit_cnt    <= 4'h0;
        drive_low  <= 1'b0;
        high_phase <= 1'b1;
        word_idx   <= 2'd0;
        read_idx   <= 2'd0;
      end else if (stop_seen) begin
        state     <= ST_IDLE;
        drive_low <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_WRITE: begin
            rx_shift <= {rx_shift[6:0], sda_in};
            bit_cnt  <= bit_cnt + 4'h1;
          end
          ST_READ: begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          ST_RACK: begin
            read_mode <= ~sda_in;                // Low means master wants more
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (byte_full && rx_shift[7:1] == DEV_ADDR) begin
              state     <= ST_AACK;
              read_mode <= rx_shift[0];
              drive_low <= 1'b1;
            end else if (byte_full) begin
              state <= ST_IDLE;
            end
          end
          ST_AACK: begin
            bit_cnt <= 4'h0;
            if (read_mode) begin
              state     <= ST_READ;
              tx_shift  <= next_tx;
              drive_low <= ~next_tx[7];
              read_idx  <= read_idx + 2'd1;
            end else begin
              state     <= ST_WRITE;
              drive_low <= 1'b0;
            end
          end
          ST_WRITE: begin
            if (byte_full) begin
              state     <= ST_WACK;
              drive_low <= 1'b1;
              bit_cnt   <= 4'h0;
              if (high_phase) begin
                high_byte  <= rx_shift;
                high_phase <= 1'b0;
              end else begin
                high_phase <= 1'b1;
                if (word_idx != 2'd3) begin
                  word_idx <= word_idx + 2'd1;
                end
                // Words without the address bit belong to other registers
                if (rx_word[`RFMOS_OPT_ADR_BIT] && !osc_disabled) begin
                  if (word_idx == 2'd0) begin
                    option_control_one <= rx_word;
                  end else if (word_idx == 2'd1) begin
                    option_control_two <= rx_word;
                  end
                end
              end
            end
          end
          ST_WACK: begin
            state     <= ST_WRITE;
            drive_low <= 1'b0;
          end
          ST_READ: begin
            if (byte_full) begin
              state     <= ST_RACK;
              drive_low <= 1'b0;
            end else begin
              tx_shift  <= {tx_shift[6:0], 1'b0};
              drive_low <= ~tx_shift[6];
            end
          end
          ST_RACK: begin
            bit_cnt <= 4'h0;
            if (read_mode) begin
              state     <= ST_READ;
              tx_shift  <= next_tx;
              drive_low <= ~next_tx[7];
              if (read_idx != `RFMOS_READ_BYTES) begin
                read_idx <= read_idx + 2'd1;
              end
            end else begin
              state     <= ST_IDLE;
              drive_low <= 1'b0;
            end
          end
          default: begin
            state     <= ST_IDLE;
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// >>> testbench/rfmos_chk.sv
// Checker for the option register and serial port outputs
`timescale 1ns/1ps
module rfmos_chk #(parameter OSC_OFF_LEVEL = 1'b0) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Bus and oscillator
  input wire logic        scl,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        osc_ctrl_bit,
  input wire logic        osc_disabled,
  // Registers
  input wire logic [15:0] option_control_one,
  input wire logic [15:0] option_control_two,
  input wire logic [1:0]  clip_level_sel,
  input wire logic [9:0]  clip_depth_permille
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Depth in tenths of a percent for each clip code
  function automatic logic [9:0] dep(input logic [1:0] c);
    return c == 2'h0 ? 10'h384 : c == 2'h1 ? 10'h3ac : c == 2'h2 ? 10'h38e : 10'h39d;
  endfunction
  // Clip select copies the register one cycle later
  sequence clip_moved;
    $changed(option_control_two[1:0]);
  endsequence
  sequence clip_copied;
    ##1 clip_level_sel == $past(option_control_two[1:0]);
  endsequence
  clip_follow_a: assert property (clip_moved |-> clip_copied) else $error("clip select lags");
  depth_map_a: assert property (clip_depth_permille == dep(clip_level_sel)) else $error("depth wrong");
  osc_state_a: assert property ($past(nrst) |-> osc_disabled == ($past(osc_ctrl_bit) == OSC_OFF_LEVEL))
    else $error("oscillator state wrong");
  opt_frozen_a: assert property (osc_disabled |=> $stable(option_control_one) && $stable(option_control_two))
    else $error("write while oscillator off");
  adr_bit_a: assert property (option_control_one[15] && option_control_two[15]) else $error("select bit lost");
  upd_ack_a: assert property ($changed(option_control_one) || $changed(option_control_two) |-> !sda_oe_n && !scl)
    else $error("update without ack");
  sda_move_a: assert property ($changed(sda_oe_n) |-> !scl && !$past(scl)) else $error("data moved with clock high");
  open_drain_a: assert property (sda_out == 1'b0) else $error("data line driven high");
endmodule
bind rfmos_regs rfmos_chk #(.OSC_OFF_LEVEL(OSC_OFF_LEVEL)) chk (.clock(clock), .nrst(nrst), .scl(scl),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .osc_ctrl_bit(osc_ctrl_bit), .osc_disabled(osc_disabled),
  .option_control_one(option_control_one), .option_control_two(option_control_two),
  .clip_level_sel(clip_level_sel), .clip_depth_permille(clip_depth_permille));

// >>> testbench/rfmos_host.sv
// Behavioural bus master on the far side of the serial port
`timescale 1ns/1ps
module rfmos_host (
  // Clock and bus lines
  input wire logic clock,
  input wire logic sda,
  output logic     scl,
  output logic     sda_drv
);
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Whole cycles, then step off the edge
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Start with the clock high
  task automatic start();
    sda_drv = 1'b0;
    w(60);
  endtask
  // Stop leaves both lines released
  task automatic stop();
    scl = 1'b0;
    w(30);
    sda_drv = 1'b0;
    w(40);
    scl = 1'b1;
    w(60);
    sda_drv = 1'b1;
    w(60);
  endtask
  // Byte plus ack slot; 70 low and 60 high keeps the clock under 800 kHz
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      w(30);
      sda_drv = tx[i];
      w(40);
      scl = 1'b1;
      w(30);
      rx[i] = sda;
      w(30);
    end
  endtask
endmodule

// >>> testbench/rfmos_regs_tb_top.sv
// Self-checking bench for the option registers and status byte
`timescale 1ns/1ps
module rfmos_regs_tb_top;
  localparam logic OFF = 1'b0;
  logic        clock = 1'b0, nrst, osc_ctrl_bit, osc_out_of_range_flag, hi, lowv;
  logic        scl, sda_drv, sda, sda_out, sda_oe_n, osc_disabled;
  logic [15:0] o1, o2;
  logic [1:0]  sel;
  logic [9:0]  dep;
  logic [8:0]  r;
  int          m1 = 16'h8000, m2 = 16'h8005, fail_count = 0, checks_done = 0, seed = 32'he1b9_167c;
  int          dtab [4] = '{900, 940, 910, 925};
  // Clock and pulled-up data line
  always #5 clock = ~clock;
  assign sda = sda_drv & (sda_oe_n | sda_out);
  rfmos_regs #(.OSC_OFF_LEVEL(OFF)) DUT (.clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .osc_ctrl_bit(osc_ctrl_bit), .vco_out_of_range(osc_out_of_range_flag), .vco_too_high(hi),
    .low_vco_active(lowv), .osc_disabled(osc_disabled), .option_control_one(o1), .option_control_two(o2),
    .clip_level_sel(sel), .clip_depth_permille(dep));
  rfmos_host host (.clock(clock), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, got, exp);
    end
  endtask
  // All register outputs against the model
  task automatic regs();
    chk(o1, m1);
    chk(o2, m2);
    chk(sel, m2[1:0]);
    chk(dep, dtab[m2[1:0]]);
    chk(osc_disabled, osc_ctrl_bit == OFF);
  endtask
  // Write two words; wrong address must not be acked
  task automatic wr(input logic [6:0] a, input logic [15:0] v1, input logic [15:0] v2);
    host.start();
    host.xfer({a, 2'b01}, r);
    chk(r[0], a != 7'h50);
    if (a == 7'h50) begin
      for (int i = 3; i >= 0; i--) begin
        host.xfer({8'({v1, v2} >> (8 * i)), 1'b1}, r);
        chk(r[0], 1'b0);
      end
      if (osc_ctrl_bit != OFF) begin
        if (v1[15]) m1 = v1;
        if (v2[15]) m2 = v2;
      end
    end
    host.stop();
    regs();
  endtask
  // Read n bytes, acking all but the last
  task automatic rd(input int n);
    logic [7:0] e [4];
    e = '{{5'h00, osc_out_of_range_flag & hi, lowv, osc_out_of_range_flag}, m1[7:0], m2[7:0], 8'hff};
    host.start();
    host.xfer({7'h50, 2'b11}, r);
    chk(r[0], 1'b0);
    for (int i = 0; i < n; i++) begin
      host.xfer({8'hff, i == n - 1}, r);
      chk(r[8:1], e[i < 3 ? i : 3]);
      if (i == 0) chk(r[3:1], e[0][2:0]);
    end
    host.stop();
  endtask
  // Counts and verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #1_000_000;
    fail_count++;
    finish_test();
  end
  // Test sequence
  initial begin
    nrst = 1'b0;
    osc_ctrl_bit = 1'b1;
    {osc_out_of_range_flag, hi, lowv} = 3'b000;
    repeat (10) @(posedge clock);
    #1 nrst = 1'b1;
    host.w(5);
    regs();
    rd(4);
    $display("test reset done");
    for (int c = 0; c < 4; c++) wr(7'h50, 16'h8000, {14'h2001, c[1:0]});
    $display("test clip done");
    wr(7'h50, 16'h0123, 16'h0006);
    wr(7'h33, 16'h8000, 16'h8005);
    $display("test refuse done");
    repeat (4) begin
      {osc_out_of_range_flag, hi, lowv} = 3'($random(seed));
      host.w(3);
      rd(2);
    end
    $display("test status done");
    osc_ctrl_bit = 1'b0;
    host.w(3);
    wr(7'h50, 16'h8000, 16'h8006);
    osc_ctrl_bit = 1'b1;
    host.w(3);
    wr(7'h50, 16'h8000, 16'h8006);
    $display("test osc done");
    nrst = 1'b0;
    host.w(2);
    nrst = 1'b1;
    m1 = 16'h8000;
    m2 = 16'h8005;
    host.w(5);
    regs();
    $display("test rerun reset done");
    finish_test();
  end
endmodule
